//--- verilog/clk_ctrl_pkg.sv
// constants shared by the clock and start-up control block.
// assumes a single 25 MHz core clock and a plain address/strobe register port.
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam logic [3:0]  ADDR_CONFIG     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_ENABLE = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_CLEAR  = 4'h4;

  // config field positions
  localparam int unsigned CFG_FAILSAFE_BIT  = 0;
  localparam int unsigned CFG_OT_SEL_BIT    = 1;
  localparam int unsigned CFG_GND_SHORT_BIT = 2;
  localparam int unsigned CFG_CHOPPER_OFF_TIME_LSB      = 4;
  localparam int unsigned CHOPPER_OFF_TIME_W            = 4;
  localparam int unsigned CFG_USED_W        = 8;
  localparam logic [7:0]  CONFIG_RESET      = 8'h00;

  // status field positions
  localparam int unsigned ST_STANDSTILL_BIT = 0;
  localparam int unsigned ST_EXT_SEL_BIT    = 1;
  localparam int unsigned ST_OSC_ON_BIT     = 2;
  localparam int unsigned ST_OVERTEMP_BIT   = 3;
  localparam int unsigned ST_DRIVER_ON_BIT  = 4;
  localparam int unsigned ST_USED_W         = 5;

  // interrupt event bits
  localparam int unsigned EV_STANDSTILL = 0;
  localparam int unsigned EV_EXT_TAKEN  = 1;
  localparam int unsigned EV_FALLBACK   = 2;
  localparam int unsigned EV_OVERTEMP   = 3;
  localparam int unsigned EV_W          = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ    = 25000000;
  localparam int unsigned GLITCH_NS      = 10;
  localparam int unsigned GLITCH_RAW     = (GLITCH_NS * (CORE_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned GLITCH_CYCLES  = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  localparam int unsigned STANDSTILL_W   = 21;
  localparam int unsigned STANDSTILL_DEF = 1048576;
  localparam int unsigned FAILSAFE_MIN   = 32;
  localparam int unsigned FAILSAFE_MAX   = 48;
  localparam int unsigned WATCHDOG_W     = 6;
  localparam logic [5:0]  FAILSAFE_TICKS = 6'h20;
  localparam int unsigned OSC_DIV_W      = 4;

  // clock source selection
  typedef enum logic [0:0] {
    SRC_INTERNAL = 1'b0,
    SRC_EXTERNAL = 1'b1
  } clk_src_t;

endpackage

//--- verilog/clk_pin_filter.sv
// glitch filter and edge detector for the external clock pin.
// assumes the pin is already synchronous to core_clk.
`timescale 1ns/10ps
module clk_pin_filter #(
  parameter int unsigned STABLE = 1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level_q,
  output logic      rise,
  output logic      edge_seen
);

  // ----------------------------------------------------------------
  // history of samples
  // ----------------------------------------------------------------
  logic [STABLE:0] hist_q;
  logic [STABLE:0] hist_d;
  logic            all_high;
  logic            all_low;
  logic            level_d;

  // shift chain built one stage per cycle of required stability
  assign hist_d[0] = pin_in;
  genvar g;
  generate
    for (g = 1; g <= STABLE; g++) begin : g_hist
      assign hist_d[g] = hist_q[g-1];
    end
  endgenerate

  // a level is accepted only once it held for the whole window
  assign all_high  = &hist_q;
  assign all_low   = ~|hist_q;
  assign level_d   = all_high ? 1'b1 : (all_low ? 1'b0 : level_q);
  assign rise      = level_d & ~level_q;
  assign edge_seen = level_d ^ level_q;

  // starts low so the first accepted high counts as a rising edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hist_q  <= '0;
      level_q <= 1'b0;
    end else begin
      hist_q  <= hist_d;
      level_q <= level_d;
    end
  end

endmodule // clk_pin_filter

//--- verilog/clk_startup_ctrl.sv
// clock source selection, start-up reset, standstill timer, thermal hysteresis.
// assumes supply monitors and temperature comparators arrive as synchronous levels.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps

module clk_startup_ctrl #(
  parameter int unsigned STANDSTILL_TICKS = clk_ctrl_pkg::STANDSTILL_DEF,
  parameter int unsigned OSC_DIV          = 2
) (
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  input  wire logic                            regulator_reset,
  input  wire logic                            io_supply_uv,
  input  wire logic                            motor_supply_uv,
  input  wire logic                            ext_clk_pin,
  input  wire logic                            step_pulse,
  input  wire logic                            power_stage_off_n,
  input  wire logic                            temp_above_150,
  input  wire logic                            temp_above_136,
  input  wire logic                            temp_below_120,
  input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clk_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [clk_ctrl_pkg::DATA_W-1:0] reg_rdata,
  output logic                                 irq,
  output logic                                 serial_reset,
  output logic                                 osc_enable,
  output logic                                 sys_tick,
  output logic                                 ext_clk_selected,
  output logic                                 standstill_flag,
  output logic                                 driver_enable,
  output logic                                 low_side_short_enable,
  output logic                                 high_side_short_sensitive,
  output logic                                 gnd_short_protect_active
);

  // ----------------------------------------------------------------
  // internal reset
  // ----------------------------------------------------------------
  logic int_reset_q;
  logic reset_req;

  // any supply source forces reset; release lands on a core_clk edge
  assign reset_req = reset | regulator_reset | io_supply_uv | motor_supply_uv;

  always_ff @(posedge core_clk) begin
    int_reset_q <= reset_req;
  end

  // serial unit held while the internal reset stands
  assign serial_reset = reset_req | int_reset_q;

  // ----------------------------------------------------------------
  // clock pin filtering
  // ----------------------------------------------------------------
  logic ext_level;
  logic ext_rise;
  logic ext_edge;

  clk_pin_filter #(
    .STABLE (clk_ctrl_pkg::GLITCH_CYCLES)
  ) u_pin_filter (
    .core_clk  (core_clk),
    .reset     (serial_reset),
    .pin_in    (ext_clk_pin),
    .level_q   (ext_level),
    .rise      (ext_rise),
    .edge_seen (ext_edge)
  );

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [clk_ctrl_pkg::CFG_USED_W-1:0] config_q;
  logic                                failsafe_en;
  logic                                ot_sel;
  logic                                gnd_short_en;
  logic [clk_ctrl_pkg::CHOPPER_OFF_TIME_W-1:0]     chopper_off_time;
  logic                                wr_ok;
  logic                                rd_ok;
  logic                                wr_config;
  logic                                wr_irq_en;
  logic                                wr_irq_clr;

  // accesses are ignored outright during internal reset
  assign wr_ok      = reg_wr & ~serial_reset;
  assign rd_ok      = reg_rd & ~serial_reset;
  assign wr_config  = wr_ok & (reg_addr == clk_ctrl_pkg::ADDR_CONFIG);
  assign wr_irq_en  = wr_ok & (reg_addr == clk_ctrl_pkg::ADDR_IRQ_ENABLE);
  assign wr_irq_clr = wr_ok & (reg_addr == clk_ctrl_pkg::ADDR_IRQ_CLEAR);

  assign failsafe_en      = config_q[clk_ctrl_pkg::CFG_FAILSAFE_BIT];
  assign ot_sel           = config_q[clk_ctrl_pkg::CFG_OT_SEL_BIT];
  assign gnd_short_en     = config_q[clk_ctrl_pkg::CFG_GND_SHORT_BIT];
  assign chopper_off_time = config_q[clk_ctrl_pkg::CFG_CHOPPER_OFF_TIME_LSB +: clk_ctrl_pkg::CHOPPER_OFF_TIME_W];

  always_ff @(posedge core_clk) begin
    if (serial_reset) begin
      config_q <= clk_ctrl_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      config_q <= reg_wdata[clk_ctrl_pkg::CFG_USED_W-1:0];
    end
  end

  // one bit steers two protections at once
  assign low_side_short_enable     = failsafe_en;
  assign high_side_short_sensitive = failsafe_en;

  // combinational from config only, so it needs no tick to stay on
  assign gnd_short_protect_active = gnd_short_en;

  // ----------------------------------------------------------------
  // internal oscillator model
  // ----------------------------------------------------------------
  logic [clk_ctrl_pkg::OSC_DIV_W-1:0] osc_cnt_q;
  logic                               osc_wrap;
  logic                               osc_tick;
  clk_ctrl_pkg::clk_src_t             src_q;

  localparam logic [clk_ctrl_pkg::OSC_DIV_W-1:0] OSC_LAST = clk_ctrl_pkg::OSC_DIV_W'(OSC_DIV - 1);

  // kept alive under failsafe since the watchdog counts its ticks
  assign osc_enable = (src_q == clk_ctrl_pkg::SRC_INTERNAL) | failsafe_en;
  assign osc_wrap   = (osc_cnt_q == OSC_LAST);
  assign osc_tick   = osc_enable & osc_wrap;

  always_ff @(posedge core_clk) begin
    if (serial_reset || !osc_enable) begin
      osc_cnt_q <= '0;
    end else if (osc_wrap) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // source selection and failsafe watchdog
  // ----------------------------------------------------------------
  clk_ctrl_pkg::clk_src_t              src_d;
  logic [clk_ctrl_pkg::WATCHDOG_W-1:0] wd_q;
  logic                                wd_expire;
  logic                                take_ext;
  logic                                fallback;

  assign wd_expire = (wd_q == clk_ctrl_pkg::FAILSAFE_TICKS);
  assign take_ext  = (src_q == clk_ctrl_pkg::SRC_INTERNAL) & ext_rise;
  assign fallback  = (src_q == clk_ctrl_pkg::SRC_EXTERNAL) & failsafe_en & wd_expire;

  // tick source switches in the cycle after an accepted pin rise or a fallback, whatever the oscillator count
  always_comb begin
    src_d = src_q;
    case (src_q)
      clk_ctrl_pkg::SRC_INTERNAL: begin
        if (ext_rise) begin
          src_d = clk_ctrl_pkg::SRC_EXTERNAL;
        end
      end
      clk_ctrl_pkg::SRC_EXTERNAL: begin
        if (fallback) begin
          src_d = clk_ctrl_pkg::SRC_INTERNAL;
        end
      end
      default: src_d = clk_ctrl_pkg::SRC_INTERNAL;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (serial_reset) begin
      src_q <= clk_ctrl_pkg::SRC_INTERNAL;
    end else begin
      src_q <= src_d;
    end
  end

  // counts oscillator ticks since the last clock pin edge
  always_ff @(posedge core_clk) begin
    if (serial_reset || ext_edge || src_q != clk_ctrl_pkg::SRC_EXTERNAL || !failsafe_en) begin
      wd_q <= '0;
    end else if (osc_tick && !wd_expire) begin
      wd_q <= wd_q + 1'b1;
    end
  end

  assign ext_clk_selected = (src_q == clk_ctrl_pkg::SRC_EXTERNAL);

  // with failsafe off and the pin quiet, no tick ever comes again
  assign sys_tick = ext_clk_selected ? ext_rise : osc_tick;

  // ----------------------------------------------------------------
  // standstill timer
  // ----------------------------------------------------------------
  logic [clk_ctrl_pkg::STANDSTILL_W-1:0] still_cnt_q;
  logic                                  still_done;
  logic                                  standstill_q;

  localparam logic [clk_ctrl_pkg::STANDSTILL_W-1:0] STILL_LAST =
    clk_ctrl_pkg::STANDSTILL_W'(STANDSTILL_TICKS - 1);

  assign still_done = (still_cnt_q == STILL_LAST);

  // a step restarts the count; the flag rises on the final tick
  always_ff @(posedge core_clk) begin
    if (serial_reset || step_pulse) begin
      still_cnt_q  <= '0;
      standstill_q <= 1'b0;
    end else if (sys_tick && !standstill_q) begin
      if (still_done) begin
        standstill_q <= 1'b1;
      end else begin
        still_cnt_q <= still_cnt_q + 1'b1;
      end
    end
  end

  assign standstill_flag = standstill_q;

  // ----------------------------------------------------------------
  // overtemperature hysteresis
  // ----------------------------------------------------------------
  logic overtemp_q;
  logic over_limit;

  assign over_limit = ot_sel ? temp_above_136 : temp_above_150;

  // latched off until the release comparator says below 120 C
  always_ff @(posedge core_clk) begin
    if (serial_reset) begin
      overtemp_q <= 1'b0;
    end else if (over_limit) begin
      overtemp_q <= 1'b1;
    end else if (temp_below_120) begin
      overtemp_q <= 1'b0;
    end
  end

  // power stage needs no reset, no thermal trip, pin low and a nonzero off time
  assign driver_enable = ~serial_reset & ~overtemp_q & ~power_stage_off_n
                       & (|chopper_off_time);

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [clk_ctrl_pkg::EV_W-1:0] irq_status_q;
  logic [clk_ctrl_pkg::EV_W-1:0] irq_enable_q;
  logic [clk_ctrl_pkg::EV_W-1:0] events;
  logic                          standstill_prev_q;
  logic                          overtemp_prev_q;

  assign events[clk_ctrl_pkg::EV_STANDSTILL] = standstill_q & ~standstill_prev_q;
  assign events[clk_ctrl_pkg::EV_EXT_TAKEN]  = take_ext;
  assign events[clk_ctrl_pkg::EV_FALLBACK]   = fallback;
  assign events[clk_ctrl_pkg::EV_OVERTEMP]   = overtemp_q & ~overtemp_prev_q;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (serial_reset) begin
      irq_status_q      <= '0;
      irq_enable_q      <= '0;
      standstill_prev_q <= 1'b0;
      overtemp_prev_q   <= 1'b0;
    end else begin
      standstill_prev_q <= standstill_q;
      overtemp_prev_q   <= overtemp_q;
      irq_status_q      <= (irq_status_q & ~({clk_ctrl_pkg::EV_W{wr_irq_clr}}
                            & reg_wdata[clk_ctrl_pkg::EV_W-1:0])) | events;
      if (wr_irq_en) begin
        irq_enable_q <= reg_wdata[clk_ctrl_pkg::EV_W-1:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [clk_ctrl_pkg::ST_USED_W-1:0] status_word;
  logic [clk_ctrl_pkg::DATA_W-1:0]    rd_mux;
  logic [clk_ctrl_pkg::DATA_W-1:0]    rdata_q;

  assign status_word[clk_ctrl_pkg::ST_STANDSTILL_BIT] = standstill_q;
  assign status_word[clk_ctrl_pkg::ST_EXT_SEL_BIT]    = ext_clk_selected;
  assign status_word[clk_ctrl_pkg::ST_OSC_ON_BIT]     = osc_enable;
  assign status_word[clk_ctrl_pkg::ST_OVERTEMP_BIT]   = overtemp_q;
  assign status_word[clk_ctrl_pkg::ST_DRIVER_ON_BIT]  = driver_enable;

  // unmapped and write-only addresses read as zero
  always_comb begin
    if (reg_addr == clk_ctrl_pkg::ADDR_CONFIG) begin
      rd_mux = {{(clk_ctrl_pkg::DATA_W-clk_ctrl_pkg::CFG_USED_W){1'b0}}, config_q};
    end else if (reg_addr == clk_ctrl_pkg::ADDR_STATUS) begin
      rd_mux = {{(clk_ctrl_pkg::DATA_W-clk_ctrl_pkg::ST_USED_W){1'b0}}, status_word};
    end else if (reg_addr == clk_ctrl_pkg::ADDR_IRQ_STATUS) begin
      rd_mux = {{(clk_ctrl_pkg::DATA_W-clk_ctrl_pkg::EV_W){1'b0}}, irq_status_q};
    end else if (reg_addr == clk_ctrl_pkg::ADDR_IRQ_ENABLE) begin
      rd_mux = {{(clk_ctrl_pkg::DATA_W-clk_ctrl_pkg::EV_W){1'b0}}, irq_enable_q};
    end else begin
      rd_mux = '0;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (serial_reset || !rd_ok) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // clk_startup_ctrl

//--- tb/clk_ctrl_props.sv
// concurrent checks on the clock and start-up control ports.
// assumes one core clock and the synchronous active-high reset input.
`timescale 1ns/10ps
module clk_ctrl_props #(
  parameter int unsigned OSC_DIV = 2
) (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        regulator_reset,
  input wire logic        io_supply_uv,
  input wire logic        motor_supply_uv,
  input wire logic        ext_clk_pin,
  input wire logic        power_stage_off_n,
  input wire logic        temp_above_150,
  input wire logic        temp_above_136,
  input wire logic        temp_below_120,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        serial_reset,
  input wire logic        osc_enable,
  input wire logic        sys_tick,
  input wire logic        ext_clk_selected,
  input wire logic        standstill_flag,
  input wire logic        driver_enable,
  input wire logic        low_side_short_enable,
  input wire logic        high_side_short_sensitive,
  input wire logic        gnd_short_protect_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // helper: cycles with the pin still while failsafe watches it
  // ------------------------------------------------------------
  logic pin_q;
  int   idle_q;
  // any pin change restarts it, so a glitch loosens the late bound but tightens the early one
  always_ff @(posedge core_clk) begin
    pin_q <= ext_clk_pin;
    if (reset || serial_reset || !ext_clk_selected || !low_side_short_enable || ext_clk_pin != pin_q) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_q + 1;
    end
  end
  AST_REG_RESET: assert property (regulator_reset |-> serial_reset) else $error("serial unit not held");
  AST_RD_REFUSED: assert property (serial_reset && reg_rd |=> reg_rdata == '0) else $error("read in reset");
  AST_IO_UV: assert property (io_supply_uv |-> serial_reset && !driver_enable) else $error("io uv no reset");
  AST_MOTOR_UV: assert property (motor_supply_uv |-> serial_reset && !driver_enable) else $error("uv on");
  AST_INT_OSC_ON: assert property (!ext_clk_selected |-> osc_enable) else $error("osc off while internal");
  AST_EXT_OSC_OFF: assert property (ext_clk_selected && !low_side_short_enable |-> !osc_enable) else $error("osc on");
  AST_NO_PIN_NO_TICK: assert property (ext_clk_selected && !low_side_short_enable && !ext_clk_pin
    && !$past(ext_clk_pin, 1) && !$past(ext_clk_pin, 2) && !$past(ext_clk_pin, 3) |-> !sys_tick)
    else $error("tick without clock");
  AST_FALLBACK_EARLY: assert property ($fell(ext_clk_selected) && !serial_reset |-> idle_q >= 32 * OSC_DIV - 4)
    else $error("fallback too soon");
  AST_FALLBACK_LATE: assert property (idle_q > 48 * OSC_DIV + 4 |-> !ext_clk_selected) else $error("no fallback");
  AST_SHORT_LINK: assert property (high_side_short_sensitive == low_side_short_enable) else $error("short split");
  AST_GND_KEEP: assert property (!reg_wr && !regulator_reset && !io_supply_uv && !motor_supply_uv
    |=> $stable(gnd_short_protect_active)) else $error("ground protect moved");
  AST_PWR_OFF: assert property (power_stage_off_n |-> !driver_enable) else $error("driver on while off");
  AST_OT_HOLD: assert property (temp_above_150 && temp_above_136 ##1 (!temp_below_120) [*4] |-> !driver_enable)
    else $error("driver back while hot");
  COV_EXT: cover property ($rose(ext_clk_selected));
  COV_FALLBACK: cover property ($fell(ext_clk_selected) && !serial_reset);
  COV_STANDSTILL: cover property ($rose(standstill_flag));
endmodule // clk_ctrl_props

bind clk_startup_ctrl clk_ctrl_props #(.OSC_DIV(OSC_DIV)) i_clk_ctrl_props (
  .core_clk, .reset, .regulator_reset, .io_supply_uv, .motor_supply_uv, .ext_clk_pin, .power_stage_off_n,
  .temp_above_150, .temp_above_136, .temp_below_120, .reg_wr, .reg_rd, .reg_rdata, .serial_reset,
  .osc_enable, .sys_tick, .ext_clk_selected, .standstill_flag, .driver_enable, .low_side_short_enable,
  .high_side_short_sensitive, .gnd_short_protect_active);

//--- tb/host_model.sv
// host side: external clock pin, step pulses and power stage switch.
// assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module host_model (
  input  wire logic core_clk,
  output logic      ext_clk_pin,
  output logic      step_pulse,
  output logic      power_stage_off_n
);
  // pin idles low as if pulled down; power stage starts off
  initial begin
    ext_clk_pin = 1'b0;
    step_pulse = 1'b0;
    power_stage_off_n = 1'b1;
  end
  // four core cycles a period: 6.25 MHz at 50 percent duty
  task automatic clock_burst(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_clk_pin <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      ext_clk_pin <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // one-cycle spike, as a reflection would give
  task automatic glitch;
    @(posedge core_clk);
    ext_clk_pin <= 1'b1;
    @(posedge core_clk);
    ext_clk_pin <= 1'b0;
  endtask
  task automatic step;
    @(posedge core_clk);
    step_pulse <= 1'b1;
    @(posedge core_clk);
    step_pulse <= 1'b0;
  endtask
  // called before any clock stop, so the coil current stays bounded
  task automatic power(input logic off);
    @(posedge core_clk);
    power_stage_off_n <= off;
  endtask
endmodule // host_model

//--- tb/tb.sv
// self-checking bench for the clock and start-up control block.
// assumes host_model drives the pin side; the bench drives the rest.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb;
  logic        core_clk, reset, regulator_reset, io_supply_uv, motor_supply_uv;
  logic        temp_above_150, temp_above_136, temp_below_120, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        ext_clk_pin, step_pulse, power_stage_off_n, irq, serial_reset, osc_enable, sys_tick;
  logic        ext_clk_selected, standstill_flag, driver_enable, low_side_short_enable;
  logic        high_side_short_sensitive, gnd_short_protect_active;
  int          num_errors, n_tests, tick_cnt, cycles;
  localparam int TICKS = 16;

  host_model i_host_model (.core_clk, .ext_clk_pin, .step_pulse, .power_stage_off_n);
  clk_startup_ctrl #(.STANDSTILL_TICKS(TICKS), .OSC_DIV(2)) i_clk_startup_ctrl (
    .core_clk, .reset, .regulator_reset, .io_supply_uv, .motor_supply_uv, .ext_clk_pin, .step_pulse,
    .power_stage_off_n, .temp_above_150, .temp_above_136, .temp_below_120, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .serial_reset, .osc_enable, .sys_tick, .ext_clk_selected, .standstill_flag,
    .driver_enable, .low_side_short_enable, .high_side_short_sensitive, .gnd_short_protect_active);

  // ------------------------------------------------------------
  // clock, tick count and hang guard
  // ------------------------------------------------------------
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (sys_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, exp)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_sources;
    chk_rd(clk_ctrl_pkg::ADDR_CONFIG, 16'h0000);
    wr(4'hF, 16'hFFFF);
    chk_rd(4'hF, 16'h0000);
    chk_rd(clk_ctrl_pkg::ADDR_IRQ_CLEAR, 16'h0000);
    i_host_model.power(1'b0);
    #1 `CHK(driver_enable, 1'b0)
    for (int k = 0; k < 3; k++) begin
      wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h0014);
      settle(1);
      `CHK(driver_enable, 1'b1)
      regulator_reset <= (k == 0);
      io_supply_uv <= (k == 1);
      motor_supply_uv <= (k == 2);
      wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h00F5);
      chk_rd(clk_ctrl_pkg::ADDR_CONFIG, 16'h0000);
      `CHK({serial_reset, driver_enable}, 2'h2)
      {motor_supply_uv, io_supply_uv, regulator_reset} <= 3'h0;
      settle(2);
      chk_rd(clk_ctrl_pkg::ADDR_CONFIG, 16'h0000);
    end
  endtask
  task automatic t_standstill;
    int cnt = 0;
    wr(clk_ctrl_pkg::ADDR_IRQ_CLEAR, 16'h000F);
    i_host_model.step();
    repeat (2 * TICKS + 8) begin
      #1 `CHK(standstill_flag, (cnt >= TICKS))
      if (sys_tick === 1'b1) cnt++;
      @(posedge core_clk);
    end
    `CHK(irq, 1'b0)
    wr(clk_ctrl_pkg::ADDR_IRQ_ENABLE, 16'h0002);
    #1 `CHK(irq, 1'b0)
    wr(clk_ctrl_pkg::ADDR_IRQ_ENABLE, 16'h0001);
    #1 `CHK(irq, 1'b1)
    wr(clk_ctrl_pkg::ADDR_IRQ_CLEAR, 16'h0001);
    #1 `CHK(irq, 1'b0)
    chk_rd(clk_ctrl_pkg::ADDR_IRQ_STATUS, 16'h0000);
  endtask
  task automatic t_overtemp;
    wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h0010);
    temp_below_120 <= 1'b0;
    temp_above_136 <= 1'b1;
    settle(3);
    `CHK(driver_enable, 1'b1)
    wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h0012);
    settle(2);
    `CHK(driver_enable, 1'b0)
    temp_above_136 <= 1'b0;
    settle(4);
    `CHK(driver_enable, 1'b0)
    temp_below_120 <= 1'b1;
    settle(3);
    `CHK(driver_enable, 1'b1)
    wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h0010);
    temp_above_150 <= 1'b1;
    temp_above_136 <= 1'b1;
    temp_below_120 <= 1'b0;
    settle(3);
    chk_rd(clk_ctrl_pkg::ADDR_STATUS, 16'h000D);
    {temp_above_150, temp_above_136, temp_below_120} <= 3'h1;
    settle(3);
    `CHK(driver_enable, 1'b1)
  endtask
  task automatic t_ext_clock;
    int t0;
    wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h0014);
    wr(clk_ctrl_pkg::ADDR_IRQ_CLEAR, 16'h000F);
    i_host_model.glitch();
    settle(4);
    `CHK(ext_clk_selected, 1'b0)
    i_host_model.clock_burst(2);
    #1 `CHK({ext_clk_selected, osc_enable}, 2'h2)
    t0 = tick_cnt;
    i_host_model.clock_burst(8);
    settle(1);
    `CHK(tick_cnt - t0, 8)
    i_host_model.power(1'b1);
    settle(1);
    `CHK(driver_enable, 1'b0)
    t0 = tick_cnt;
    settle(200);
    `CHK(tick_cnt - t0, 0)
    `CHK({ext_clk_selected, gnd_short_protect_active}, 2'h3)
    chk_rd(clk_ctrl_pkg::ADDR_IRQ_STATUS, 16'h0002);
  endtask
  task automatic t_failsafe;
    int n = 0, t0;
    i_host_model.power(1'b0);
    wr(clk_ctrl_pkg::ADDR_CONFIG, 16'h0011);
    wr(clk_ctrl_pkg::ADDR_IRQ_ENABLE, 16'h0004);
    #1 `CHK({low_side_short_enable, high_side_short_sensitive, irq}, 3'h6)
    i_host_model.clock_burst(4);
    #1 `CHK({ext_clk_selected, osc_enable}, 2'h3)
    i_host_model.power(1'b1);
    while (ext_clk_selected === 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    `CHK((n >= 32 * 2 - 4 && n <= 48 * 2 + 4), 1'b1)
    `CHK(irq, 1'b1)
    t0 = tick_cnt;
    settle(20);
    `CHK(tick_cnt - t0, 10)
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {core_clk, regulator_reset, io_supply_uv, motor_supply_uv, reg_wr, reg_rd} = 6'h00;
    {temp_above_150, temp_above_136, temp_below_120} = 3'h1;
    {reg_addr, reg_wdata, num_errors, n_tests, tick_cnt, cycles} = '0;
    reset = 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    settle(2);
    t_reset_sources();
    t_standstill();
    t_overtemp();
    t_ext_clock();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    settle(2);
    t_failsafe();
    tally_and_finish();
  end
endmodule // tb
